// File: rtl/rws_regs.svh
`ifndef RWS_REGS_SVH
`define RWS_REGS_SVH

// ****************************************************************
// Word layout and channel count
// ****************************************************************
`define RWS_CHANNELS 3
`define RWS_EXP_W 3
`define RWS_TAG_W 2
`define RWS_MAN_W 5
`define RWS_WORD_W 10
`define RWS_WORD_TAG_LSB 8
`define RWS_WORD_EXP_LSB 5
`define RWS_WORD_MAN_LSB 0
`define RWS_FRAME_W 30

// ****************************************************************
// Pipeline latencies in clock ticks
// ****************************************************************
`define RWS_ENC_DEPTH 4
`define RWS_ENC_OUT 1
`define RWS_FLASH_LAT 1
`define RWS_SYNC_LAT 2
`define RWS_ENC_LAT (`RWS_ENC_DEPTH + `RWS_ENC_OUT)
`define RWS_TOTAL_LAT (`RWS_ENC_LAT + `RWS_FLASH_LAT + `RWS_SYNC_LAT)

// ****************************************************************
// Rates
// ****************************************************************
`define RWS_CLK_HZ 20000000
`define RWS_LINK_BPS 1200000000
`define RWS_SC_HZ 1000000
`define RWS_SC_DIV (`RWS_CLK_HZ / `RWS_SC_HZ)
`define RWS_SC_DIV_W 5

// ****************************************************************
// Monitor set and slow-control scan chain
// ****************************************************************
`define RWS_MON_W 8
`define RWS_MON_N 8
`define RWS_MON_VOLT 0
`define RWS_MON_CURR 1
`define RWS_TEMP_ELEC_N 4
`define RWS_TEMP_OPT_N 2
`define RWS_LIMIT_RST 8'hff
`define RWS_STATUS_W 8
`define RWS_SH_W 72
`define RWS_SH_CLR_BIT 64

`endif

// File: rtl/rws_pkg.sv
`include "rws_regs.svh"
`default_nettype none

package rws_pkg;

    typedef enum logic [3:0]
    {
        RWS_SC_IDLE = 4'h1,
        RWS_SC_CAPTURE = 4'h2,
        RWS_SC_SHIFT = 4'h4,
        RWS_SC_UPDATE = 4'h8
    } rws_sc_state_type;

    typedef logic [`RWS_MON_N-1:0][`RWS_MON_W-1:0] rws_mon_set_type;

    typedef struct packed
    {
        logic [`RWS_TAG_W+`RWS_EXP_W-1:0] held;
        logic [`RWS_WORD_W-1:0] word;
        logic [`RWS_TAG_W-1:0] prev_tag;
        logic slip;
    } rws_lane_state_type;

    typedef struct packed
    {
        logic over;
    } rws_cmp_state_type;

    typedef struct packed
    {
        logic [`RWS_TOTAL_LAT-1:0] vpipe;
        logic [`RWS_FRAME_W-1:0] frame;
        logic [`RWS_CHANNELS-1:0] slip;
        logic tck_q;
        logic [`RWS_SC_DIV_W-1:0] gap;
        logic [`RWS_SC_DIV_W-1:0] mon_div;
        rws_sc_state_type st;
        logic [`RWS_SH_W-1:0] shreg;
        logic tdo;
        logic tdo_en;
        rws_mon_set_type limits;
        rws_mon_set_type snap;
        logic shutdown;
        logic power_en;
    } rws_top_state_type;

endpackage

`default_nettype wire

// File: rtl/rws_lane_if.sv
`include "rws_regs.svh"
`default_nettype none

interface rws_lane_if;
    logic [`RWS_EXP_W-1:0] exponent;
    logic [`RWS_TAG_W-1:0] capacitor_tag;
    logic [`RWS_MAN_W-1:0] mantissa;
    logic check_ok;
    logic [`RWS_WORD_W-1:0] word;
    logic tag_slip;

    modport lane_side
    (
        input exponent,
        input capacitor_tag,
        input mantissa,
        input check_ok,
        output word,
        output tag_slip
    );

    modport feed_side
    (
        output exponent,
        output capacitor_tag,
        output mantissa,
        output check_ok,
        input word,
        input tag_slip
    );
endinterface

`default_nettype wire

// File: rtl/rws_lane.sv
`include "rws_regs.svh"
`default_nettype none

module rws_lane
(
    input wire logic clk_i,
    input wire logic rst_i,
    rws_lane_if.lane_side lane
);

    rws_pkg::rws_lane_state_type s;
    rws_pkg::rws_lane_state_type next_s;

    // ****************************************************************
    // Alignment of one channel
    // ****************************************************************
    always_comb
    begin
        next_s = s;
        // Exponent and tag wait one tick for the mantissa of the same sample
        next_s.held = {lane.capacitor_tag, lane.exponent};
        next_s.word = {s.held, lane.mantissa};
        next_s.prev_tag = lane.capacitor_tag;
        // Capacitors are used in strict rotation, so a skip means lost alignment
        next_s.slip = lane.check_ok &&
            (lane.capacitor_tag != `RWS_TAG_W'(s.prev_tag + 1'h1));
        if (rst_i)
        begin
            next_s = '0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        s <= next_s;
    end

    assign lane.word = s.word;
    assign lane.tag_slip = s.slip;

endmodule

`default_nettype wire

// File: rtl/rws_limit_cmp.sv
`default_nettype none

module rws_limit_cmp
#(
    parameter int W = 8
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic [W-1:0] value_i,
    input wire logic [W-1:0] limit_i,
    output logic over_o
);

    rws_pkg::rws_cmp_state_type s;
    rws_pkg::rws_cmp_state_type next_s;

    always_comb
    begin
        next_s = s;
        if (en_i)
        begin
            next_s.over = value_i > limit_i;
        end
        if (rst_i)
        begin
            next_s = '0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        s <= next_s;
    end

    assign over_o = s.over;

endmodule

`default_nettype wire

// File: rtl/rws_top.sv
// Functional notes
// - Encoder outputs valid fixed ticks after sampling
// - Encoder pipeline four deep plus output tick
// - Three-bit exponent taken every tick
// - Exponent goes straight into synchroniser
// - Two-bit capacitor tag travels with exponent
// - Five-bit mantissa arrives one tick later
// - Alignment takes two ticks, eight in total
// - Word is tag, exponent, mantissa
// - Word handed to parallel-to-serial converter
// - One new word per channel every tick
// - Three channels share one serial frame
// - Slow-control scan link limited to 1 MHz
// - Supply readings snapshotted for control-room readback
// - Supply excursion shuts the system down
// - Six temperatures checked, power removed on excess
// - Scan chain passes through for daisy-chaining
`include "rws_regs.svh"
`default_nettype none

module rws_top
(
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic [`RWS_CHANNELS-1:0][`RWS_EXP_W-1:0] EXPONENT_I,
    input wire logic [`RWS_CHANNELS-1:0][`RWS_TAG_W-1:0] CAP_TAG_I,
    input wire logic [`RWS_CHANNELS-1:0][`RWS_MAN_W-1:0] MANTISSA_I,
    output logic [`RWS_FRAME_W-1:0] FRAME_O,
    output logic FRAME_VALID_O,
    output logic [`RWS_CHANNELS-1:0] TAG_SLIP_O,
    input wire logic [`RWS_MON_W-1:0] MON_VOLT_I,
    input wire logic [`RWS_MON_W-1:0] MON_CURR_I,
    input wire logic [`RWS_TEMP_ELEC_N-1:0][`RWS_MON_W-1:0] TEMP_ELEC_I,
    input wire logic [`RWS_TEMP_OPT_N-1:0][`RWS_MON_W-1:0] TEMP_OPT_I,
    input wire logic SC_TCK_I,
    input wire logic SC_TMS_I,
    input wire logic SC_TDI_I,
    input wire logic SC_RST_N_I,
    output logic SC_TDO_O,
    output logic SC_TDO_EN_O,
    output logic SHUTDOWN_O,
    output logic POWER_EN_O
);

    localparam logic [`RWS_SC_DIV_W-1:0] SC_LAST = `RWS_SC_DIV_W'(`RWS_SC_DIV - 1);

    rws_pkg::rws_top_state_type s;
    rws_pkg::rws_top_state_type next_s;

    logic [`RWS_CHANNELS-1:0][`RWS_WORD_W-1:0] lane_word;
    logic [`RWS_CHANNELS-1:0] lane_slip;
    logic [`RWS_MON_N-1:0] over;
    rws_pkg::rws_mon_set_type mon_now;
    logic any_over;
    logic mon_tick;
    logic tck_rise;
    logic [`RWS_STATUS_W-1:0] status;

    // ****************************************************************
    // Channel lanes
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < `RWS_CHANNELS; g++)
        begin : gen_lane
            rws_lane_if lif();

            assign lif.exponent = EXPONENT_I[g];
            assign lif.capacitor_tag = CAP_TAG_I[g];
            assign lif.mantissa = MANTISSA_I[g];
            // Tag rotation is only checked once two valid encoder ticks exist
            assign lif.check_ok = s.vpipe[`RWS_ENC_LAT];
            assign lane_word[g] = lif.word;
            assign lane_slip[g] = lif.tag_slip;

            rws_lane u_lane
            (
                .clk_i(MCLK_I),
                .rst_i(RESET_I),
                .lane(lif)
            );
        end
    endgenerate

    // ****************************************************************
    // Monitor readings and limit comparators
    // ****************************************************************
    assign mon_now = {TEMP_OPT_I, TEMP_ELEC_I, MON_CURR_I, MON_VOLT_I};

    generate
        for (g = 0; g < `RWS_MON_N; g++)
        begin : gen_cmp
            rws_limit_cmp
            #(
                .W(`RWS_MON_W)
            )
            u_cmp
            (
                .clk_i(MCLK_I),
                .rst_i(RESET_I),
                .en_i(mon_tick),
                .value_i(mon_now[g]),
                .limit_i(s.limits[g]),
                .over_o(over[g])
            );
        end
    endgenerate

    assign any_over = |over;
    assign mon_tick = (s.mon_div == SC_LAST);
    // Edges closer than one slow-control bit period are ignored
    assign tck_rise = SC_TCK_I && !s.tck_q && (s.gap == SC_LAST);
    assign status = {5'h00, any_over, !s.power_en, s.shutdown};

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        next_s = s;

        // ****************************************************************
        // Data path
        // ****************************************************************
        // Valid marker walks the same depth as a sample: encoder, flash, sync
        next_s.vpipe = {s.vpipe[`RWS_TOTAL_LAT-2:0], 1'h1};
        // Channel 0 sits in the top bits, channel 2 in the bottom bits
        next_s.frame = {lane_word[0], lane_word[1], lane_word[2]};
        next_s.slip = lane_slip;

        // ****************************************************************
        // Slow-control bit timing
        // ****************************************************************
        next_s.tck_q = SC_TCK_I;
        if (tck_rise)
        begin
            next_s.gap = '0;
        end
        else if (s.gap != SC_LAST)
        begin
            next_s.gap = `RWS_SC_DIV_W'(s.gap + 1'h1);
        end
        if (mon_tick)
        begin
            next_s.mon_div = '0;
        end
        else
        begin
            next_s.mon_div = `RWS_SC_DIV_W'(s.mon_div + 1'h1);
        end

        // ****************************************************************
        // Monitor snapshot
        // ****************************************************************
        // Readings are frozen at a steady rate so a slow scan sees one set
        if (mon_tick)
        begin
            next_s.snap = mon_now;
        end

        // ****************************************************************
        // Scan state machine
        // ****************************************************************
        case (s.st)
            rws_pkg::RWS_SC_IDLE:
            begin
                if (tck_rise && SC_TMS_I)
                begin
                    next_s.shreg = {status, s.snap};
                    next_s.st = rws_pkg::RWS_SC_CAPTURE;
                end
            end
            rws_pkg::RWS_SC_CAPTURE:
            begin
                if (tck_rise)
                begin
                    next_s.st = SC_TMS_I ? rws_pkg::RWS_SC_IDLE : rws_pkg::RWS_SC_SHIFT;
                end
            end
            rws_pkg::RWS_SC_SHIFT:
            begin
                if (tck_rise && SC_TMS_I)
                begin
                    next_s.st = rws_pkg::RWS_SC_UPDATE;
                end
                else if (tck_rise)
                begin
                    // LSB leaves first so crates can be chained TDO to TDI
                    next_s.shreg = {SC_TDI_I, s.shreg[`RWS_SH_W-1:1]};
                end
            end
            rws_pkg::RWS_SC_UPDATE:
            begin
                next_s.limits = s.shreg[`RWS_SH_CLR_BIT-1:0];
                next_s.st = rws_pkg::RWS_SC_IDLE;
            end
            default:
            begin
                next_s.st = rws_pkg::RWS_SC_IDLE;
            end
        endcase
        if (!SC_RST_N_I)
        begin
            next_s.st = rws_pkg::RWS_SC_IDLE;
        end
        next_s.tdo = next_s.shreg[0];
        next_s.tdo_en = (next_s.st == rws_pkg::RWS_SC_SHIFT);

        // ****************************************************************
        // Shutdown
        // ****************************************************************
        // A clear is honoured only when no reading is over; a set always wins
        if ((s.st == rws_pkg::RWS_SC_UPDATE) && s.shreg[`RWS_SH_CLR_BIT])
        begin
            next_s.shutdown = 1'h0;
        end
        if (any_over)
        begin
            next_s.shutdown = 1'h1;
        end
        next_s.power_en = !next_s.shutdown;

        // ****************************************************************
        // Reset
        // ****************************************************************
        if (RESET_I)
        begin
            next_s = '0;
            next_s.st = rws_pkg::RWS_SC_IDLE;
            next_s.limits = {`RWS_MON_N{`RWS_LIMIT_RST}};
            next_s.power_en = 1'h1;
        end
    end

    always_ff @(posedge MCLK_I)
    begin
        s <= next_s;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Frame goes out every tick without gaps to the external serialiser
    assign FRAME_O = s.frame;
    assign FRAME_VALID_O = s.vpipe[`RWS_TOTAL_LAT-1];
    assign TAG_SLIP_O = s.slip;
    assign SC_TDO_O = s.tdo;
    assign SC_TDO_EN_O = s.tdo_en;
    assign SHUTDOWN_O = s.shutdown;
    assign POWER_EN_O = s.power_en;

endmodule

`default_nettype wire

// File: rtl/rws_top_end.sv
`default_nettype none
`default_nettype wire

// File: test/rws_top_chk.sv
`default_nettype none

module rws_top_chk
(
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic [2:0][2:0] EXPONENT_I,
    input wire logic [2:0][1:0] CAP_TAG_I,
    input wire logic [2:0][4:0] MANTISSA_I,
    input wire logic [29:0] FRAME_O,
    input wire logic FRAME_VALID_O,
    input wire logic [2:0] TAG_SLIP_O,
    input wire logic [7:0] MON_VOLT_I,
    input wire logic [7:0] MON_CURR_I,
    input wire logic [3:0][7:0] TEMP_ELEC_I,
    input wire logic [1:0][7:0] TEMP_OPT_I,
    input wire logic SC_TCK_I,
    input wire logic SC_TMS_I,
    input wire logic SC_TDI_I,
    input wire logic SC_RST_N_I,
    input wire logic SC_TDO_O,
    input wire logic SC_TDO_EN_O,
    input wire logic SHUTDOWN_O,
    input wire logic POWER_EN_O
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Properties
    // ****************************************
    logic tdo_q;
    logic [4:0] tdo_gap;

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RESET_I);

    // Starts saturated so the first move after reset is never judged
    always_ff @(posedge MCLK_I)
    begin
        tdo_q <= SC_TDO_O;
        if (RESET_I)
            tdo_gap <= 5'h1f;
        else if (SC_TDO_O != tdo_q)
            tdo_gap <= 5'h00;
        else if (tdo_gap != 5'h1f)
            tdo_gap <= tdo_gap + 5'h01;
    end

    property p_valid_start;
        $fell(RESET_I) |-> !FRAME_VALID_O[*8] ##1 FRAME_VALID_O;
    endproperty
    a_valid_start: assert property (p_valid_start)
        else $error("frame valid not raised eight ticks after reset");

    for (genvar c = 0; c < 3; c++)
    begin : g_ch
        property p_word;
            FRAME_VALID_O |-> FRAME_O[29-c*10 -: 10] == {$past(CAP_TAG_I[c], 3),
                $past(EXPONENT_I[c], 3), $past(MANTISSA_I[c], 2)};
        endproperty
        a_word: assert property (p_word)
            else $error("channel word not aligned with its inputs");

        property p_slip_set;
            FRAME_VALID_O && CAP_TAG_I[c] != $past(CAP_TAG_I[c]) + 2'h1 |-> ##2 TAG_SLIP_O[c];
        endproperty
        a_slip_set: assert property (p_slip_set)
            else $error("tag step missed");

        property p_slip_cause;
            TAG_SLIP_O[c] |-> $past(CAP_TAG_I[c], 2) != $past(CAP_TAG_I[c], 3) + 2'h1;
        endproperty
        a_slip_cause: assert property (p_slip_cause)
            else $error("tag slip without cause");
    end

    property p_power;
        POWER_EN_O != SHUTDOWN_O;
    endproperty
    a_power: assert property (p_power)
        else $error("power enable not opposite to shutdown");

    property p_clear;
        $fell(SHUTDOWN_O) && !$past(RESET_I) |->
            $past(SC_TDO_EN_O) || $past(SC_TDO_EN_O, 2) || $past(SC_TDO_EN_O, 3);
    endproperty
    a_clear: assert property (p_clear)
        else $error("shutdown cleared outside a scan update");

    property p_tck_gap;
        SC_TDO_O != tdo_q |-> tdo_gap >= 5'h13;
    endproperty
    a_tck_gap: assert property (p_tck_gap)
        else $error("scan output moved faster than the link rate");

    property p_sc_rst;
        !SC_RST_N_I |-> ##2 !SC_TDO_EN_O;
    endproperty
    a_sc_rst: assert property (p_sc_rst)
        else $error("scan reset did not end shifting");

    c_slip: cover property (TAG_SLIP_O != 3'h0);
    c_shift: cover property ($rose(SC_TDO_EN_O));
    c_shut: cover property ($rose(SHUTDOWN_O));
    c_clear: cover property ($fell(SHUTDOWN_O));
endmodule

bind rws_top rws_top_chk u_chk
(
    .MCLK_I, .RESET_I, .EXPONENT_I, .CAP_TAG_I, .MANTISSA_I, .FRAME_O, .FRAME_VALID_O,
    .TAG_SLIP_O, .MON_VOLT_I, .MON_CURR_I, .TEMP_ELEC_I, .TEMP_OPT_I, .SC_TCK_I,
    .SC_TMS_I, .SC_TDI_I, .SC_RST_N_I, .SC_TDO_O, .SC_TDO_EN_O, .SHUTDOWN_O, .POWER_EN_O
);

`default_nettype wire

// File: test/rws_rx_model.sv
`default_nettype none

module rws_rx_model
(
    input wire logic [29:0] frame_i,
    input wire logic valid_i,
    output logic [2:0][9:0] word_o,
    output logic valid_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Receiver split
    // ****************************************
    // Channel 0 rides on top, so no per-frame marker is needed
    always_comb
    begin
        for (int c = 0; c < 3; c++)
        begin
            word_o[c] = frame_i[29-c*10 -: 10];
        end
        valid_o = valid_i;
    end
endmodule

`default_nettype wire

// File: test/readout_word_synchroniser_test.sv
`default_nettype none

module readout_word_synchroniser_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [2:0][2:0] expo = '0;
    logic [2:0][1:0] tag = '0;
    logic [2:0][4:0] man = '0;
    logic [7:0] volt = '0;
    logic [7:0] curr = '0;
    logic [3:0][7:0] te = '0;
    logic [1:0][7:0] topt = '0;
    logic tck = 1'b0;
    logic tms = 1'b0;
    logic tdi = 1'b0;
    logic sc_rst_n = 1'b0;
    logic [29:0] frame;
    logic [2:0] slip;
    logic [2:0][9:0] rx_word;
    logic fvalid, rx_valid, tdo, tdo_en, shut, pwr;
    logic [2:0][1:0] q_t[$];
    logic [2:0][2:0] q_e[$];
    logic [2:0][4:0] q_m[$];
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int ticks = 0;

    always #25 mclk = ~mclk;

    rws_top dut
    (
        .MCLK_I(mclk), .RESET_I(rst), .EXPONENT_I(expo), .CAP_TAG_I(tag), .MANTISSA_I(man),
        .FRAME_O(frame), .FRAME_VALID_O(fvalid), .TAG_SLIP_O(slip), .MON_VOLT_I(volt),
        .MON_CURR_I(curr), .TEMP_ELEC_I(te), .TEMP_OPT_I(topt), .SC_TCK_I(tck),
        .SC_TMS_I(tms), .SC_TDI_I(tdi), .SC_RST_N_I(sc_rst_n), .SC_TDO_O(tdo),
        .SC_TDO_EN_O(tdo_en), .SHUTDOWN_O(shut), .POWER_EN_O(pwr)
    );

    rws_rx_model rx
    (
        .frame_i(frame), .valid_i(fvalid), .word_o(rx_word), .valid_o(rx_valid)
    );

    // ****************************************
    // Checking and stimulus
    // ****************************************
    task automatic chk_word(input string name, input logic [9:0] e, input logic [9:0] g);
        n_tests++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_flag(input string name, input logic e, input logic g);
        n_tests++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", name, e, g);
        end
    endtask

    task automatic print_verdict();
        if (error_cnt == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Edges 24 cycles apart stay under the slow-control rate
    task automatic sc_edge(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        repeat (12) @(posedge mclk);
        q = tdo;
        tck <= 1'b1;
        repeat (12) @(posedge mclk);
        tck <= 1'b0;
    endtask

    task automatic scan(input logic [71:0] din, input logic [7:0] stat);
        logic q;
        logic [71:0] cap;
        logic [71:0] want;
        want = {stat, topt, te, curr, volt};
        sc_edge(1'b1, 1'b0, q);
        sc_edge(1'b0, 1'b0, q);
        for (int i = 0; i < 72; i++)
        begin
            sc_edge(1'b0, din[i], cap[i]);
            chk_flag("capture_bit", want[i], cap[i]);
            chk_flag("tdo_en", 1'b1, tdo_en);
        end
        sc_edge(1'b1, 1'b0, q);
        repeat (50) @(posedge mclk);
    endtask

    // Ceiling is several times the length of all scenarios together
    always @(posedge mclk)
    begin
        ticks++;
        if (ticks == 20000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    // Model: words rebuilt from what was presented three and two ticks earlier
    always @(posedge mclk)
    begin
        logic [2:0][1:0] nt;
        q_t.push_front(tag);
        q_e.push_front(expo);
        q_m.push_front(man);
        if (q_t.size() > 4)
        begin
            void'(q_t.pop_back());
            void'(q_e.pop_back());
            void'(q_m.pop_back());
        end
        if (rst)
            cyc = 0;
        else
        begin
            chk_flag("frame_valid", cyc >= 8, rx_valid);
            for (int c = 0; c < 3; c++)
            begin
                if (cyc >= 8)
                    chk_word("word", {q_t[3][c], q_e[3][c], q_m[2][c]}, rx_word[c]);
                chk_flag("slip", cyc >= 8 && q_t[2][c] != q_t[3][c] + 2'h1, slip[c]);
            end
            cyc++;
        end
        for (int c = 0; c < 3; c++)
        begin
            nt[c] = ($urandom % 16 == 0) ? 2'($urandom) : tag[c] + 2'h1;
        end
        tag <= nt;
        expo <= 9'($urandom);
        man <= 15'($urandom);
    end

    initial
    begin
        logic q;
        void'($urandom(32'h0a27eaf5));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        sc_rst_n <= 1'b1;
        volt <= 8'($urandom);
        curr <= 8'($urandom);
        te <= $urandom;
        topt <= {8'h80, 8'($urandom)};
        repeat (60) @(posedge mclk);
        scan({8'h00, 8'h7f, {7{8'hff}}}, 8'h00);
        chk_flag("shutdown", 1'b1, shut);
        chk_flag("power_en", 1'b0, pwr);
        topt[1] <= 8'h10;
        repeat (50) @(posedge mclk);
        scan({8'h01, {8{8'hff}}}, 8'h03);
        chk_flag("shutdown", 1'b0, shut);
        chk_flag("power_en", 1'b1, pwr);
        // Capture with mode select held high drops back to idle, no shifting
        sc_edge(1'b1, 1'b0, q);
        sc_edge(1'b1, 1'b0, q);
        chk_flag("tdo_en", 1'b0, tdo_en);
        // Scan reset in mid-shift abandons the chain at once
        sc_edge(1'b1, 1'b0, q);
        sc_edge(1'b0, 1'b0, q);
        chk_flag("tdo_en", 1'b1, tdo_en);
        sc_rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        chk_flag("tdo_en", 1'b0, tdo_en);
        sc_rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        print_verdict();
    end
endmodule

`default_nettype wire
